// ===== sss_pkg.sv
package sss_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] OFS_CONTROL_ONE = 8'h00;
	localparam logic [7:0] OFS_STATUS      = 8'h04;
	localparam logic [7:0] OFS_BUFFER      = 8'h08;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h0c;
	localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h10;
	localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h14;

	// Field positions
	localparam int unsigned CTL_WRITE_COLLISION_FLAG_BIT = 7;
	localparam int unsigned CTL_OVF_BIT  = 6;
	localparam int unsigned STA_SMP_BIT  = 7;
	localparam int unsigned STA_CKE_BIT  = 6;
	localparam int unsigned STA_BF_BIT   = 0;
	localparam int unsigned IRQ_RX_BIT   = 0;
	localparam int unsigned IRQ_WRITE_COLLISION_FLAG_BIT = 1;
	localparam int unsigned IRQ_OVF_BIT  = 2;
	localparam int unsigned IRQ_W        = 3;

	// Reset values
	localparam logic [7:0]       CTL_RESET = 8'h00;
	localparam logic [7:0]       BUF_RESET = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

	// Transfer shape
	localparam int unsigned WORD_BITS   = 8;
	localparam logic [4:0]  LAST_EDGE   = 5'h10;
	localparam logic [3:0]  FULL_COUNT  = 4'h8;

	// Master half-period counts in system clocks
	localparam logic [7:0] HALF_DIV4  = 8'h02;
	localparam logic [7:0] HALF_DIV16 = 8'h08;
	localparam logic [7:0] HALF_DIV64 = 8'h20;

	// Port mode field
	typedef enum logic [3:0] {
		MODE_M_DIV4   = 4'h0,
		MODE_M_DIV16  = 4'h1,
		MODE_M_DIV64  = 4'h2,
		MODE_M_TIMER  = 4'h3,
		MODE_S_SEL    = 4'h4,
		MODE_S_NOSEL  = 4'h5
	} sss_mode_e;

	// Control register one layout
	typedef struct packed {
		logic       write_collision_flag;
		logic       ovf;
		logic       en;
		logic       ckp;
		logic [3:0] mode;
	} sss_ctrl_s;

	// Transfer engine states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_DONE = 2'b11
	} sss_state_e;

endpackage : sss_pkg

// ===== sss_sync.sv
`timescale 1ns/1ps
module sss_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         i_sys_clk,
	input  wire logic         i_resetn,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] q1;
	logic [W-1:0] q2;
	logic [W-1:0] q3;
	logic [W-1:0] next_sync;

	// A bit moves only once stages two and three agree
	always_comb begin
		for (int i = 0; i < W; i++) begin
			next_sync[i] = (q2[i] == q3[i]) ? q3[i] : o_sync[i];
		end
	end

	// Stage one feeds stage two only
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			q1     <= '0;
			q2     <= '0;
			q3     <= '0;
			o_sync <= '0;
		end else begin
			q1     <= i_async;
			q2     <= q1;
			q3     <= q2;
			o_sync <= next_sync;
		end
	end
endmodule : sss_sync

// ===== sss_tick_gen.sv
`timescale 1ns/1ps
module sss_tick_gen #(
	parameter int unsigned W = 8
) (
	input  wire logic         i_sys_clk,
	input  wire logic         i_resetn,
	input  wire logic         i_run,
	input  wire logic [W-1:0] i_half,
	output logic              o_tick
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic         next_tick;

	// One pulse per half period of the serial clock
	always_comb begin
		next_cnt  = '0;
		next_tick = 1'b0;
		if (i_run) begin
			if (cnt >= i_half - W'(1)) begin
				next_tick = 1'b1;
			end else begin
				next_cnt = cnt + W'(1);
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			cnt    <= '0;
			o_tick <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			o_tick <= next_tick;
		end
	end
endmodule : sss_tick_gen

// ===== sss_spi_port.sv
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module sss_spi_port #(
	parameter logic [7:0] TIMER_HALF = 8'h80
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_sck,
	output logic             o_sck,
	output logic             o_sck_oe,
	input  wire logic        i_sdi,
	output logic             o_sdo,
	output logic             o_sdo_oe,
	input  wire logic        i_ss_n,
	output logic             o_irq
);
	import sss_pkg::*;

	// Mode decode shared by several paths
	function automatic logic is_spi_code(input logic [3:0] m);
		return m <= MODE_S_NOSEL;
	endfunction : is_spi_code

	function automatic logic is_master_code(input logic [3:0] m);
		return m <= MODE_M_TIMER;
	endfunction : is_master_code

	sss_ctrl_s          ctl;
	sss_ctrl_s          next_ctl;
	logic               sample_phase_select;
	logic               next_smp;
	logic               cke;
	logic               next_cke;
	logic               bf;
	logic               next_bf;
	logic [7:0]         buffer;
	logic [7:0]         next_buffer;
	logic [7:0]         tx_sr;
	logic [7:0]         next_tx_sr;
	logic [7:0]         rx_sr;
	logic [7:0]         next_rx_sr;
	logic [3:0]         samp_cnt;
	logic [3:0]         next_samp_cnt;
	logic [4:0]         edge_cnt;
	logic [4:0]         next_edge_cnt;
	logic               sck_q;
	logic               next_sck_q;
	logic               sck_prev;
	sss_state_e         state;
	sss_state_e         next_state;
	logic [IRQ_W-1:0]   irq_sta;
	logic [IRQ_W-1:0]   next_irq_sta;
	logic [IRQ_W-1:0]   irq_en;
	logic [IRQ_W-1:0]   next_irq_en;
	logic               ack;
	logic               next_ack;
	logic [31:0]        rdata;
	logic [31:0]        next_rdata;
	logic [2:0]         pins_s;
	logic               sck_s;
	logic               sdi_s;
	logic               ss_n_s;
	logic               tick;
	logic [7:0]         half;
	logic               spi_on;
	logic               master;
	logic               slave;
	logic               selected;
	logic               ev;
	logic [4:0]         t;
	logic               samp_ev;
	logic               out_ev;
	logic               wr_buf;
	logic               rd_buf;
	logic               wr_ok;
	logic               set_write_collision_flag;
	logic               set_ovf;
	logic               set_rx;

	// Pins from the other party cross into the system clock
	sss_sync #(.W(3)) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_async   ({i_sck, i_sdi, i_ss_n}),
		.o_sync    (pins_s)
	);
	assign sck_s  = pins_s[2];
	assign sdi_s  = pins_s[1];
	assign ss_n_s = pins_s[0];

	// Master bit rate from the mode code
	always_comb begin
		unique case (ctl.mode)
			MODE_M_DIV4:  half = HALF_DIV4;
			MODE_M_DIV16: half = HALF_DIV16;
			MODE_M_DIV64: half = HALF_DIV64;
			default:      half = TIMER_HALF;
		endcase
	end

	sss_tick_gen #(.W(8)) u_tick (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_run     (master && state == ST_RUN),
		.i_half    (half),
		.o_tick    (tick)
	);

	// Role and event decode
	assign spi_on   = ctl.en && is_spi_code(ctl.mode);
	assign master   = spi_on && is_master_code(ctl.mode);
	assign slave    = spi_on && !is_master_code(ctl.mode);
	assign selected = (ctl.mode != MODE_S_SEL) || !ss_n_s;
	assign ev       = master ? tick : (slave && selected && sck_s != sck_prev && state != ST_DONE);
	assign t        = edge_cnt + 5'h01;
	// Sample edge is opposite the output edge; master end sampling moves it one half later, onto the output edge
	assign samp_ev  = ev && (t[0] == (cke ^ (master && sample_phase_select))) && !(t == 5'h01 && !cke);
	assign out_ev   = ev && (cke ? !t[0] : (t[0] && t != 5'h01));
	assign wr_buf   = ack && i_avs_write && i_avs_address == OFS_BUFFER && i_avs_byteenable[0];
	assign rd_buf   = ack && i_avs_read && i_avs_address == OFS_BUFFER;
	assign wr_ok    = wr_buf && state == ST_IDLE && edge_cnt == 5'h00;
	assign set_write_collision_flag = wr_buf && !wr_ok;
	assign set_ovf  = state == ST_DONE && bf && slave;
	assign set_rx   = state == ST_DONE;

	// Transfer engine
	always_comb begin
		next_state    = state;
		next_tx_sr    = tx_sr;
		next_rx_sr    = rx_sr;
		next_samp_cnt = samp_cnt;
		next_edge_cnt = edge_cnt;
		next_sck_q    = sck_q;
		next_buffer   = buffer;
		next_bf       = bf;
		if (wr_ok) begin
			next_buffer = i_avs_writedata[7:0];
			next_tx_sr  = i_avs_writedata[7:0];
			if (master) begin
				next_state = ST_RUN;
			end
		end
		if (ev) begin
			next_edge_cnt = t;
			if (master && t <= LAST_EDGE) begin
				next_sck_q = !sck_q;
			end
			if (slave) begin
				next_state = ST_RUN;
			end
			if (out_ev) begin
				next_tx_sr = {tx_sr[6:0], 1'b0};
			end
			if (samp_ev) begin
				next_rx_sr    = {rx_sr[6:0], sdi_s};
				next_samp_cnt = samp_cnt + 4'h1;
			end
			// Wait for the last clock edge, not just the last sample
			if (next_samp_cnt == FULL_COUNT && t >= LAST_EDGE) begin
				next_state    = ST_DONE;
				next_edge_cnt = '0;
				next_samp_cnt = '0;
			end
		end
		if (state == ST_DONE) begin
			next_state = ST_IDLE;
			if (!set_ovf) begin
				next_buffer = rx_sr;
			end
			next_bf = 1'b1;
		end else if (rd_buf) begin
			next_bf = 1'b0;
		end
		// Deselect or leaving SPI aborts a partial byte
		if (!spi_on || (slave && !selected)) begin
			next_state    = ST_IDLE;
			next_edge_cnt = '0;
			next_samp_cnt = '0;
		end
		if (!master || state == ST_IDLE) begin
			next_sck_q = ctl.ckp;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			state    <= ST_IDLE;
			tx_sr    <= BUF_RESET;
			rx_sr    <= BUF_RESET;
			samp_cnt <= '0;
			edge_cnt <= '0;
			sck_q    <= 1'b0;
			sck_prev <= 1'b0;
			buffer   <= BUF_RESET;
			bf       <= 1'b0;
		end else begin
			state    <= next_state;
			tx_sr    <= next_tx_sr;
			rx_sr    <= next_rx_sr;
			samp_cnt <= next_samp_cnt;
			edge_cnt <= next_edge_cnt;
			sck_q    <= next_sck_q;
			sck_prev <= sck_s;
			buffer   <= next_buffer;
			bf       <= next_bf;
		end
	end

	// Register file and bus answer; one wait state per access
	always_comb begin
		next_ctl     = ctl;
		next_smp     = sample_phase_select;
		next_cke     = cke;
		next_irq_en  = irq_en;
		next_irq_sta = irq_sta;
		next_ack     = (i_avs_read || i_avs_write) && !ack;
		next_rdata   = rdata;
		if (ack && i_avs_write && i_avs_byteenable[0]) begin
			unique case (i_avs_address)
				OFS_CONTROL_ONE: next_ctl = sss_ctrl_s'(i_avs_writedata[7:0]);
				OFS_STATUS: begin
					next_smp = i_avs_writedata[STA_SMP_BIT];
					next_cke = i_avs_writedata[STA_CKE_BIT];
				end
				OFS_IRQ_ENABLE:  next_irq_en  = i_avs_writedata[IRQ_W-1:0];
				OFS_IRQ_CLEAR:   next_irq_sta = irq_sta & ~i_avs_writedata[IRQ_W-1:0];
				default:         next_ctl = ctl;
			endcase
		end
		// Hardware sets win over a clear in the same cycle
		if (set_write_collision_flag) begin
			next_ctl.write_collision_flag               = 1'b1;
			next_irq_sta[IRQ_WRITE_COLLISION_FLAG_BIT]  = 1'b1;
		end
		if (set_ovf) begin
			next_ctl.ovf                = 1'b1;
			next_irq_sta[IRQ_OVF_BIT]   = 1'b1;
		end
		if (set_rx) begin
			next_irq_sta[IRQ_RX_BIT]    = 1'b1;
		end
		if (next_ack && i_avs_read) begin
			next_rdata = '0;
			unique case (i_avs_address)
				OFS_CONTROL_ONE: next_rdata[7:0] = ctl;
				OFS_STATUS:      next_rdata[7:0] = {sample_phase_select, cke, 5'h00, bf};
				OFS_BUFFER:      next_rdata[7:0] = buffer;
				OFS_IRQ_STATUS:  next_rdata[IRQ_W-1:0] = irq_sta;
				OFS_IRQ_ENABLE:  next_rdata[IRQ_W-1:0] = irq_en;
				default:         next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			ctl     <= sss_ctrl_s'(CTL_RESET);
			sample_phase_select     <= 1'b0;
			cke     <= 1'b0;
			irq_en  <= IRQ_RESET;
			irq_sta <= IRQ_RESET;
			ack     <= 1'b0;
			rdata   <= '0;
		end else begin
			ctl     <= next_ctl;
			sample_phase_select     <= next_smp;
			cke     <= next_cke;
			irq_en  <= next_irq_en;
			irq_sta <= next_irq_sta;
			ack     <= next_ack;
			rdata   <= next_rdata;
		end
	end

	// Outputs; data out only drives while this end may talk
	assign o_avs_readdata    = rdata;
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack;
	assign o_sck             = sck_q;
	assign o_sck_oe          = master;
	assign o_sdo             = tx_sr[WORD_BITS-1];
	assign o_sdo_oe          = master || (slave && selected);
	assign o_irq             = |(irq_sta & irq_en);
endmodule : sss_spi_port

// ===== sss_spi_port_asserts.sv
`timescale 1ns/1ps
// Port-level relations of the bus handshake and the pins
module sss_spi_port_asserts (
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] o_avs_readdata,
	input  wire logic        o_avs_waitrequest,
	input  wire logic        o_sck,
	input  wire logic        o_sck_oe,
	input  wire logic        o_sdo_oe,
	input  wire logic        o_irq
);
	import sss_pkg::*;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	// Read answered in this cycle
	wire logic rd_ack = i_avs_read && !o_avs_waitrequest;

	AST_ONE_WAIT: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("request waited more than one cycle");
	AST_REQ_WAITS: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
		else $error("new request not held off");
	AST_IDLE_NO_WAIT: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
		else $error("waitrequest without request");
	AST_UPPER_ZERO: assert property (rd_ack |-> o_avs_readdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	AST_STATUS_RSVD: assert property (rd_ack && i_avs_address == OFS_STATUS |-> o_avs_readdata[5:1] == 5'h0)
		else $error("unused status bits not zero");
	AST_CLEAR_WO: assert property (rd_ack && i_avs_address == OFS_IRQ_CLEAR |-> o_avs_readdata == 32'h0)
		else $error("clear register reads nonzero");
	AST_SDO_DRIVEN: assert property (o_sck_oe |-> o_sdo_oe)
		else $error("master clock driven without data out");
	AST_SCK_HALF: assert property (o_sck_oe && $past(o_sck_oe) && $changed(o_sck) |=> $stable(o_sck))
		else $error("serial clock level shorter than two cycles");
	AST_IRQ_FALL: assert property ($fell(o_irq) |-> $past(i_avs_write && !o_avs_waitrequest))
		else $error("interrupt dropped without a register write");
endmodule : sss_spi_port_asserts

bind sss_spi_port sss_spi_port_asserts i_chk (.i_sys_clk, .i_resetn, .i_avs_address, .i_avs_read,
	.i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .o_sck, .o_sck_oe, .o_sdo_oe, .o_irq);

// ===== sss_spi_peer.sv
`timescale 1ns/1ps
// Far-side slave: shifts its byte out, captures the master's byte
module sss_spi_peer (
	input  wire logic       i_sck,
	input  wire logic       i_sdo,
	input  wire logic       i_ckp,
	input  wire logic       i_cke,
	input  wire logic       i_load,
	input  wire logic [7:0] i_tx,
	output logic            o_miso,
	output logic [7:0]      o_rx
);
	logic [7:0] tx;
	// Load must follow any clock-polarity change, which looks like an edge here
	always @(i_sck, posedge i_load) begin
		if (i_load) begin
			tx = i_tx;
			o_miso = tx[7];
		end else if ((i_sck !== i_ckp) == i_cke) begin
			o_rx = {o_rx[6:0], i_sdo};
		end else if (i_cke) begin
			tx = {tx[6:0], ~tx[0]};
			o_miso = tx[7];
		end else begin
			o_miso = tx[7];
			tx = {tx[6:0], ~tx[0]};
		end
	end
endmodule : sss_spi_peer

// ===== testbench.sv
`timescale 1ns/1ps
// Register, master and slave scenarios around one port
module testbench;
	import sss_pkg::*;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic        tsck = 1'b0;
	logic        tsdi = 1'b0;
	logic        tssn = 1'b1;
	logic        ld = 1'b0;
	logic [7:0]  ptx = 8'h00;
	logic        pckp = 1'b0;
	logic        pcke = 1'b0;
	logic [31:0] rdat;
	logic        wrq, osck, sckoe, sdo, sdooe, irq, miso;
	logic [7:0]  prx;
	int          num_errors = 0;
	int          cmp_count = 0;

	always #20 clk = ~clk;
	// Pins: master mode loops through the peer, slave mode is driven here
	// Timer half period long enough for the four-flop sample lag on the loopback
	sss_spi_port #(.TIMER_HALF(8'h06)) i_sss_spi_port (.i_sys_clk(clk), .i_resetn(rstn),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.i_avs_byteenable(4'hf), .o_avs_readdata(rdat), .o_avs_waitrequest(wrq),
		.i_sck(sckoe ? osck : tsck), .o_sck(osck), .o_sck_oe(sckoe), .i_sdi(sckoe ? miso : tsdi),
		.o_sdo(sdo), .o_sdo_oe(sdooe), .i_ss_n(tssn), .o_irq(irq));
	sss_spi_peer i_sss_spi_peer (.i_sck(osck), .i_sdo(sdo), .i_ckp(pckp), .i_cke(pcke),
		.i_load(ld), .i_tx(ptx), .o_miso(miso), .o_rx(prx));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask : tk
	// Request held until waitrequest is low at a rising edge; one idle edge after
	// Values read right after an edge are those the design sampled there; the watchdog ends a hang
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
		adr <= a;
		wd <= {24'h0, d};
		rd <= !w;
		wr <= w;
		do begin
			@(posedge clk);
		end while (wrq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr8
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(nm, q, exp);
	endtask : rdc
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		chk("irq", irq, 1'b1);
	endtask : wait_irq
	task automatic t_regs();
		rdc("ctl", OFS_CONTROL_ONE, 32'h0);
		rdc("sta", OFS_STATUS, 32'h0);
		rdc("buf", OFS_BUFFER, 32'h0);
		rdc("ist", OFS_IRQ_STATUS, 32'h0);
		rdc("ien", OFS_IRQ_ENABLE, 32'h0);
		rdc("gap", 8'h20, 32'h0);
		rdc("clr", OFS_IRQ_CLEAR, 32'h0);
		wr8(OFS_CONTROL_ONE, 8'h1f);
		rdc("ctl", OFS_CONTROL_ONE, 32'h1f);
		wr8(OFS_STATUS, 8'hff);
		rdc("sta", OFS_STATUS, 32'hc0);
		wr8(OFS_STATUS, 8'h00);
		wr8(OFS_CONTROL_ONE, 8'h26);
		chk("off", {sckoe, sdooe}, 2'b00);
		wr8(OFS_CONTROL_ONE, 8'h00);
	endtask : t_regs
	// Master byte exchange per clock mode (received byte not checked for i of 0), with a colliding write mid-transfer
	task automatic t_master(input logic [1:0] i);
		logic [31:0] q;
		logic [7:0]  tx;
		logic [7:0]  rx;
		logic [7:0]  st;
		tx = 8'ha5 ^ {4{i}};
		rx = 8'h3c ^ {i, 6'h0};
		st = {i == 2'd0, i[1], 6'h0};
		pckp <= i[0];
		pcke <= i[1];
		ptx <= rx;
		wr8(OFS_STATUS, st);
		wr8(OFS_IRQ_ENABLE, 8'h01);
		wr8(OFS_CONTROL_ONE, {3'b001, i[0], 2'b00, i});
		ld <= 1'b1;
		tk(1);
		ld <= 1'b0;
		wr8(OFS_BUFFER, tx);
		wr8(OFS_BUFFER, 8'hff);
		rdc("write_collision_flag", OFS_CONTROL_ONE, {24'h0, 3'b101, i[0], 2'b00, i});
		chk("mask", irq, 1'b0);
		rdc("bf0", OFS_STATUS, {24'h0, st});
		wait_irq();
		rdc("bf1", OFS_STATUS, {24'h0, st | 8'h01});
		if (i != 2'd0) rdc("rx", OFS_BUFFER, {24'h0, rx});
		else bus(1'b0, OFS_BUFFER, 8'h00, q);
		rdc("bf2", OFS_STATUS, {24'h0, st});
		chk("ptx", prx, tx);
		rdc("ist", OFS_IRQ_STATUS, 32'h3);
		wr8(OFS_IRQ_CLEAR, 8'h07);
		chk("clr", irq, 1'b0);
		wr8(OFS_CONTROL_ONE, 8'h00);
	endtask : t_master
	// Bench as master at 320 ns: data moved on falling edge, read on rising
	task automatic frame(input logic [7:0] d, output logic [7:0] got);
		tssn <= 1'b0;
		tk(4);
		for (int b = 7; b >= 0; b--) begin
			tsdi <= d[b];
			tk(4);
			tsck <= 1'b1;
			tk(2);
			got[b] = sdo;
			tk(2);
			tsck <= 1'b0;
		end
		tk(4);
		tssn <= 1'b1;
		tk(1);
	endtask : frame
	// Slave receive, then a second byte into a full buffer
	task automatic t_slave(input logic [3:0] m);
		logic [7:0] got;
		wr8(OFS_STATUS, 8'h40);
		wr8(OFS_IRQ_ENABLE, 8'h01);
		wr8(OFS_CONTROL_ONE, {4'h2, m});
		chk("oe", sdooe, m == 4'h5);
		wr8(OFS_BUFFER, 8'h96);
		frame(8'hc3, got);
		chk("sdo", got, 8'h96);
		wait_irq();
		frame(8'h5a, got);
		tk(8);
		rdc("ovf", OFS_CONTROL_ONE, {24'h0, 4'h6, m});
		rdc("ist", OFS_IRQ_STATUS, 32'h5);
		rdc("buf", OFS_BUFFER, 32'hc3);
		wr8(OFS_IRQ_ENABLE, 8'h00);
		chk("ien", irq, 1'b0);
		wr8(OFS_IRQ_CLEAR, 8'h07);
		rdc("ist", OFS_IRQ_STATUS, 32'h0);
		wr8(OFS_CONTROL_ONE, 8'h00);
	endtask : t_slave
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	// Hang guard, far beyond the expected few thousand cycles
	initial begin
		#2000000;
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_regs();
		for (int i = 0; i < 4; i++) t_master(i[1:0]);
		t_slave(4'h4);
		t_slave(4'h5);
		end_sim();
	end
endmodule : testbench
